//--- dv/core_memory_model.sv
// Purpose: core memory on the shared bus, logs every dump write
// Assumes: one request at a time, write only
// Notes:   slow sets extra wait cycles before acknowledge
`timescale 1ns/10ps
`default_nettype none
module core_memory_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        mem_request,
  input  wire logic        mem_write,
  input  wire logic [17:0] mem_address,
  input  wire logic [17:0] mem_write_data,
  input  wire logic [3:0]  slow,
  output var  logic        mem_ack
);
  logic [17:0] addr_log [0:127];
  logic [17:0] data_log [0:127];
  logic [6:0]  count;
  logic [3:0]  waited;
  // ack stays up until the request drops, so it always falls between words
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      waited <= 4'h0;
      count <= 7'h00;
    end else if (!mem_request) begin
      mem_ack <= 1'b0;
      waited <= 4'h0;
    end else if (!mem_ack && waited >= slow) begin
      mem_ack <= 1'b1;
      addr_log[count] <= mem_address;
      data_log[count] <= mem_write_data;
      count <= count + 7'h01;
    end else if (!mem_ack) begin
      waited <= waited + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- dv/diagnostic_step_and_dump_bench.sv
// Purpose: self-checking bench for diagnostic stepping and dump
// Assumes: core state driven as levels, one-cycle pulses
// Notes:   memory partner logs the sixteen words of each dump
`timescale 1ns/10ps
`default_nettype none
module diagnostic_step_and_dump_bench;
  logic clock, rst_n, diagnostic_enable_instruction, instruction_strobe, phase_two_pulse, phase_three_pulse;
  logic unit_clock_active, busy, fetch_state, operand_read_state, alignment_major_state, arithmetic_major_state;
  logic normalize_state, write_state, interrupt_one_state, interrupt_two_state, first_time_state, second_time_state;
  logic third_time_state, mantissa_matching_shift_pulse, second_operand_right_shift, multiply_divide_shift_pulse;
  logic integer_divide_shift_pulse, fix_shift_pulse, leading_zero_shift_pulse, a_sign, b_sign, guard_bit, mem_ack;
  logic mem_request, mem_write, clock_run, clear_unit, return_control, normal_path, maintenance_mode, dump_done_flag;
  logic [17:0]  instruction_word, argument_address, buffer_upper, buffer_lower, exponent_a, mant_a_lower, exponent_b;
  logic [17:0]  mant_b_lower, quotient_lower, adder_upper, adder_lower, operand_pointer_register, mem_address;
  logic [17:0]  mem_write_data, packed_state_word, subroutine_return_register;
  logic [16:0]  mant_a_upper, mant_b_upper, quotient_upper;
  logic [14:0]  exit_address;
  logic [11:0]  instruction_low, core;
  logic [5:0]   shift_count, step_count, shifts;
  logic [4:0]   output_word_counter;
  logic [3:0]   slow;
  logic [266:0] blob;
  int           errors, total_checks;
  assign {third_time_state, second_time_state, first_time_state, interrupt_two_state, interrupt_one_state, write_state,
          normalize_state, arithmetic_major_state, alignment_major_state, operand_read_state, fetch_state, busy} = core;
  assign {leading_zero_shift_pulse, fix_shift_pulse, integer_divide_shift_pulse, multiply_divide_shift_pulse,
          second_operand_right_shift, mantissa_matching_shift_pulse} = shifts;
  assign {buffer_upper, buffer_lower, shift_count, instruction_low, exponent_a, a_sign, mant_a_upper, mant_a_lower,
          exponent_b, b_sign, mant_b_upper, mant_b_lower, quotient_upper, quotient_lower, adder_upper, adder_lower,
          guard_bit, exit_address, operand_pointer_register} = blob;
  diagnostic_step_and_dump DUT (.*);
  core_memory_model memory (.*);
  initial clock = 1'b0;
  always #25 clock = ~clock;
  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [17:0] got, input logic [17:0] want);
    total_checks++;
    if (got !== want) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task fill(input int seed);
    for (int i = 0; i < 267; i++) blob[i] = ((i * seed + i / 5) % 7) < 3;
  endtask
  task issue(input logic [17:0] word, input logic [17:0] addr);
    instruction_word = word;
    argument_address = addr;
    instruction_strobe = 1'b1;
    tick(1);
    instruction_strobe = 1'b0;
  endtask
  // one core event: shift pulses and phase pulses for a single cycle
  task pulse(input logic [5:0] sh, input logic p2, input logic p3);
    shifts = sh;
    phase_two_pulse = p2;
    phase_three_pulse = p3;
    tick(1);
    {shifts, phase_two_pulse, phase_three_pulse} = 8'h00;
    tick(2);
  endtask
  function automatic logic [17:0] exp_word(input int i);
    case (i)
      0: return buffer_upper;
      1: return buffer_lower;
      2: return {shift_count, instruction_low};
      3: return exponent_a;
      4: return {mant_a_upper, a_sign};
      5: return mant_a_lower;
      6: return exponent_b;
      7: return {mant_b_upper, b_sign};
      8: return mant_b_lower;
      9: return {quotient_upper, b_sign};
      10: return quotient_lower;
      11: return adder_upper;
      12: return adder_lower;
      13: return {exit_address, 1'b0, guard_bit, a_sign};
      14: return {6'h00, core};
      default: return operand_pointer_register;
    endcase
  endfunction
  task wait_done(input int base, input logic [17:0] addr);
    int k;
    for (k = 0; k < 3000 && return_control !== 1'b1; k++) tick(1);
    if (k == 3000) begin
      errors++;
      finish_test();
    end
    check(clear_unit, 1'b1);
    check(dump_done_flag, 1'b1);
    tick(2);
    check(18'(memory.count - base), 18'h00010);
    for (int i = 0; i < 16; i++) begin
      check(memory.addr_log[base + i], addr + 18'(i));
      check(memory.data_log[base + i], exp_word(i));
    end
  endtask
  task test_normal;
    int k;
    core = 12'h803;
    issue(18'h39000, 18'h00100);
    for (k = 0; k < 4 && normal_path !== 1'b1; k++) tick(1);
    check(normal_path, 1'b1);
    check(mem_request, 1'b0);
  endtask
  task test_dump_only;
    int base;
    diagnostic_enable_instruction = 1'b1;
    tick(1);
    diagnostic_enable_instruction = 1'b0;
    check(maintenance_mode, 1'b1);
    fill(37);
    for (int r = 0; r < 2; r++) begin
      slow = r ? 4'h5 : 4'h0;
      base = memory.count;
      issue(18'h39000, 18'h01000 + 18'(r * 32));
      wait_done(base, 18'h01000 + 18'(r * 32));
      check(clock_run, 1'b0);
      tick(2);
    end
  endtask
  task test_step;
    int base;
    fill(11);
    slow = 4'h2;
    core = 12'h803;
    base = memory.count;
    issue(18'h39048, 18'h02000);
    tick(1);
    check(clock_run, 1'b1);
    check(step_count, 6'h08);
    check(packed_state_word, {6'h08, 12'h803});
    unit_clock_active = 1'b1;
    tick(2);
    core = 12'h002;
    pulse(6'h00, 1'b1, 1'b0);
    check(step_count, 6'h08);
    core = 12'h802;
    pulse(6'h00, 1'b1, 1'b0);
    check(step_count, 6'h07);
    core = 12'h008;
    pulse(6'h00, 1'b1, 1'b0);
    check(step_count, 6'h06);
    for (int k = 0; k < 6; k++) begin
      pulse(6'h01 << k, 1'b0, 1'b0);
      check(step_count, 6'h05 - 6'(k));
      check(clock_run, k != 5);
    end
    wait_done(base, 18'h02000);
    unit_clock_active = 1'b0;
  endtask
  task test_cycle_end(input logic fin);
    int base, k;
    fill(fin ? 5 : 9);
    core = 12'h803;
    base = memory.count;
    issue(18'h39040, 18'h03000);
    tick(1);
    unit_clock_active = 1'b1;
    tick(2);
    core = fin ? 12'h080 : 12'h841;
    pulse(6'h00, 1'b0, 1'b1);
    check(clock_run, fin);
    wait_done(base, 18'h03000);
    unit_clock_active = 1'b0;
    issue(18'h39000, 18'h04000);
    for (k = 0; k < 4 && normal_path !== 1'b1; k++) tick(1);
    check(normal_path, fin);
    if (!fin) wait_done(base + 16, 18'h04000);
  endtask
  initial begin
    errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    {diagnostic_enable_instruction, instruction_strobe, phase_two_pulse, phase_three_pulse, unit_clock_active} = 5'h00;
    {core, shifts, slow} = 22'h000000;
    instruction_word = 18'h00000;
    argument_address = 18'h00000;
    blob = '0;
    tick(6);
    rst_n = 1'b1;
    check(output_word_counter, 5'h00);
    check(step_count, 6'h00);
    check({dump_done_flag, maintenance_mode, clock_run}, 3'h0);
    test_normal();
    test_dump_only();
    test_step();
    test_cycle_end(1'b0);
    test_cycle_end(1'b1);
    finish_test();
  end
endmodule
`default_nettype wire

//--- dv/diagnostic_step_and_dump_checker.sv
// Purpose: concurrent checks on the diagnostic step-and-dump ports
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into every instance of the design
`timescale 1ns/10ps
`default_nettype none
module diagnostic_step_and_dump_checker (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        instruction_strobe,
  input wire logic        busy,
  input wire logic        a_sign,
  input wire logic        guard_bit,
  input wire logic        mem_request,
  input wire logic        mem_write,
  input wire logic        clock_run,
  input wire logic        clear_unit,
  input wire logic        return_control,
  input wire logic        normal_path,
  input wire logic        maintenance_mode,
  input wire logic        dump_done_flag,
  input wire logic [14:0] exit_address,
  input wire logic [17:0] mem_address,
  input wire logic [17:0] subroutine_return_register,
  input wire logic [5:0]  step_count,
  input wire logic [4:0]  output_word_counter
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic        up;
  logic [17:0] last_addr;
  // keeps the previous word's address across the gap between requests
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      up <= 1'b0;
      last_addr <= 18'h00000;
    end else begin
      up <= 1'b1;
      if (mem_request) last_addr <= mem_address;
    end
  end
  a_request_writes: assert property (mem_request |-> mem_write) else $error("request without write");
  a_counter_bumps: assert property ($fell(mem_request) |->
    output_word_counter == $past(output_word_counter) + 5'h01) else $error("word counter not bumped");
  a_request_holds: assert property ($past(mem_request) && mem_request |->
    $stable(mem_address) && $stable(output_word_counter)) else $error("request changed mid cycle");
  a_address_steps: assert property (up && $rose(mem_request) && output_word_counter != 5'h00 &&
    output_word_counter != 5'h10 |-> mem_address == last_addr + 18'h00001) else $error("address not consecutive");
  a_done_at_sixteen: assert property ($rose(dump_done_flag) |->
    output_word_counter == 5'h10 && !mem_request) else $error("done flag not at sixteen");
  a_return_after_done: assert property ($rose(dump_done_flag) |-> ##[1:4] (clear_unit && return_control))
    else $error("control not returned");
  a_clear_pairs: assert property (clear_unit |-> return_control && dump_done_flag)
    else $error("clear without return");
  a_return_layout: assert property (up |-> subroutine_return_register ==
    {$past(exit_address), 1'b0, $past(guard_bit), $past(a_sign)}) else $error("return register layout");
  a_step_no_rise: assert property (up && !$past(instruction_strobe) && !$past(instruction_strobe, 2) |->
    step_count <= $past(step_count)) else $error("step count rose");
  a_normal_strobe: assert property (instruction_strobe && (!busy || !maintenance_mode) && !mem_request &&
    !clock_run |-> ##[1:2] normal_path) else $error("normal path missed");
  a_reset_clear: assert property ($rose(rst_n) |-> output_word_counter == 5'h00 && !dump_done_flag &&
    step_count == 6'h00 && !maintenance_mode && !clock_run) else $error("reset state wrong");
endmodule
bind diagnostic_step_and_dump diagnostic_step_and_dump_checker checker_i (.*);
`default_nettype wire

//--- shared/diag_regs.vh
// Purpose: constants for the diagnostic step-and-dump control
// Assumes: 18-bit words, bit numbers given low-order first
// Notes:   field positions of the packed state word and return register
`ifndef DIAG_REGS_VH
`define DIAG_REGS_VH

`define WORD_W            18
`define DUMP_WORDS        16
`define DUMP_IDX_W        4
`define DUMP_CNT_W        5
`define STEP_MODE_BIT     6
`define STEP_CNT_W        6
`define STEP_CNT_LSB      0

`define STA_BUSY          0
`define STA_FETCH         1
`define STA_OPERAND       2
`define STA_ALIGN         3
`define STA_ARITH         4
`define STA_NORMALIZE     5
`define STA_WRITE         6
`define STA_INT1          7
`define STA_INT2          8
`define STA_TS1           9
`define STA_TS2           10
`define STA_TS3           11
`define STA_STEP_LSB      12

`define RET_SIGN          0
`define RET_GUARD         1
`define RET_UNUSED        2
`define RET_EXIT_LSB      3
`define RET_EXIT_W        15

`define RST_WORD          18'h00000
`define RST_STEP          6'h00
`define RST_DUMP_CNT      5'h00

`endif

//--- verilog/diagnostic_step_and_dump.v
// Purpose: maintenance-mode stepping and register dump of the coprocessor
// Assumes: core state inputs on the same clock; memory acknowledge is asynchronous
// Notes:   mem_ack is synchronised by two flip-flops before use
//
// What this block does
// RULE_01: start one memory write per dumped word; bump word counter after each.
// RULE_02: state word: busy, six major states, two interrupt phases, time states, step bits.
// RULE_03: bump dump pointer each word; sixteen words land consecutively from argument address.
// RULE_04: word counter carry at sixteen sets dump-done, clears unit, returns control.
// RULE_05: repeated dump-only leaves the suspended instruction untouched.
// RULE_06: step-mode bit set means step the suspended instruction before dumping.
// RULE_07: stepping follows the instruction's own cycle path through the core.
// RULE_08: restart the stopped unit clock before judging whether a step happened.
// RULE_09: count a step at time state 3 phase 2, or phase 2 in arithmetic cycles.
// RULE_10: every alignment, right, multiply/divide, fix and normalize shift is a step.
// RULE_11: decrement the held step count once per counted step.
// RULE_12: software issues the step instruction with the step count in low bits.
// RULE_13: keep stepping while steps remain and no cycle end or interrupt reached.
// RULE_14: at cycle end or interrupt with busy set, stop clock and dump.
// RULE_15: at that point with instruction finished, dump without stopping clock.
// RULE_16: after sixteen words complete the cycle, clear unit, return control.
// RULE_17: next instruction is diagnostic if busy stays set, normal path otherwise.
// RULE_18: return register: sign bit 0, guard bit 1, bit 2 zero, exit address 3-17.
// RULE_19: step-mode bit clear means dump only, without advancing the instruction.
// RULE_20: dumped words follow one fixed order ending with the address register.
// RULE_21: software turns maintenance mode on before any stepping or dumping.
// RULE_22: reset clears word counter, dump-done, step count, maintenance mode, clock idle.
`timescale 1ns/10ps
`default_nettype none
`include "diag_regs.vh"

module diagnostic_step_and_dump #(
  parameter WORD_W = `WORD_W
) (
  input  wire              clock,
  input  wire              rst_n,
  // instruction intake
  input  wire              diagnostic_enable_instruction,
  input  wire              instruction_strobe,
  input  wire [17:0]       instruction_word,
  input  wire [17:0]       argument_address,
  // core state
  input  wire              busy,
  input  wire              fetch_state,
  input  wire              operand_read_state,
  input  wire              alignment_major_state,
  input  wire              arithmetic_major_state,
  input  wire              normalize_state,
  input  wire              write_state,
  input  wire              interrupt_one_state,
  input  wire              interrupt_two_state,
  input  wire              first_time_state,
  input  wire              second_time_state,
  input  wire              third_time_state,
  input  wire              phase_two_pulse,
  input  wire              phase_three_pulse,
  input  wire              unit_clock_active,
  // shift pulses
  input  wire              mantissa_matching_shift_pulse,
  input  wire              second_operand_right_shift,
  input  wire              multiply_divide_shift_pulse,
  input  wire              integer_divide_shift_pulse,
  input  wire              fix_shift_pulse,
  input  wire              leading_zero_shift_pulse,
  // register contents to dump
  input  wire [17:0]       buffer_upper,
  input  wire [17:0]       buffer_lower,
  input  wire [5:0]        shift_count,
  input  wire [11:0]       instruction_low,
  input  wire [17:0]       exponent_a,
  input  wire              a_sign,
  input  wire [16:0]       mant_a_upper,
  input  wire [17:0]       mant_a_lower,
  input  wire [17:0]       exponent_b,
  input  wire              b_sign,
  input  wire [16:0]       mant_b_upper,
  input  wire [17:0]       mant_b_lower,
  input  wire [16:0]       quotient_upper,
  input  wire [17:0]       quotient_lower,
  input  wire [17:0]       adder_upper,
  input  wire [17:0]       adder_lower,
  input  wire              guard_bit,
  input  wire [14:0]       exit_address,
  input  wire [17:0]       operand_pointer_register,
  // memory side
  input  wire              mem_ack,
  output reg               mem_request,
  output reg               mem_write,
  output reg  [17:0]       mem_address,
  output reg  [17:0]       mem_write_data,
  // control back to the core and CPU
  output reg               clock_run,
  output reg               clear_unit,
  output reg               return_control,
  output reg               normal_path,
  output reg               maintenance_mode,
  output reg               dump_done_flag,
  output reg  [5:0]        step_count,
  output reg  [4:0]        output_word_counter,
  output reg  [17:0]       packed_state_word,
  output reg  [17:0]       subroutine_return_register
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_STEP = 5'h02;
  localparam [4:0] S_REQ  = 5'h04;
  localparam [4:0] S_WAIT = 5'h08;
  localparam [4:0] S_DONE = 5'h10;

  reg  [4:0]        state;
  reg  [4:0]        next_state;
  reg  [17:0]       dump_pointer_register;
  reg               ack_meta;
  reg               ack_sync;
  reg               ack_prev;
  reg               step_armed;
  wire              ack_rise;
  wire              in_arith_cycles;
  wire              step_event;
  wire              cycle_end;
  wire              word_counter_overflow;
  wire [17:0]       state_word;
  wire [17:0]       return_word;
  wire [17:0]       dump_word;
  wire [4:0]        counter_plus;

  // packed state word assembly
  assign state_word[`STA_BUSY]      = busy; // [RULE_02]
  assign state_word[`STA_FETCH]     = fetch_state;
  assign state_word[`STA_OPERAND]   = operand_read_state;
  assign state_word[`STA_ALIGN]     = alignment_major_state;
  assign state_word[`STA_ARITH]     = arithmetic_major_state;
  assign state_word[`STA_NORMALIZE] = normalize_state;
  assign state_word[`STA_WRITE]     = write_state;
  assign state_word[`STA_INT1]      = interrupt_one_state;
  assign state_word[`STA_INT2]      = interrupt_two_state;
  assign state_word[`STA_TS1]       = first_time_state;
  assign state_word[`STA_TS2]       = second_time_state;
  assign state_word[`STA_TS3]       = third_time_state;
  assign state_word[WORD_W-1:`STA_STEP_LSB] = step_count; // [RULE_02]

  // return register layout
  assign return_word = {exit_address, 1'b0, guard_bit, a_sign}; // [RULE_18]

  // the core walks its own cycle path; only its state flags are watched here [RULE_07]
  assign in_arith_cycles = alignment_major_state | arithmetic_major_state | normalize_state;

  assign step_event = (third_time_state & phase_two_pulse & ~in_arith_cycles)     // [RULE_09]
                    | (phase_two_pulse & unit_clock_active & in_arith_cycles)     // [RULE_09]
                    | mantissa_matching_shift_pulse | second_operand_right_shift  // [RULE_10]
                    | multiply_divide_shift_pulse | integer_divide_shift_pulse    // [RULE_10]
                    | fix_shift_pulse | leading_zero_shift_pulse;                 // [RULE_10]

  assign cycle_end = (third_time_state & phase_three_pulse & (normalize_state | write_state))
                   | interrupt_one_state | interrupt_two_state;

  assign counter_plus          = output_word_counter + 5'h01;
  assign word_counter_overflow = counter_plus[`DUMP_CNT_W-1]; // [RULE_04]
  assign ack_rise              = ack_sync & ~ack_prev;

  dump_word_select u_select (
    .word_index               (output_word_counter[`DUMP_IDX_W-1:0]),
    .buffer_upper             (buffer_upper),
    .buffer_lower             (buffer_lower),
    .shift_count              (shift_count),
    .instruction_low          (instruction_low),
    .exponent_a               (exponent_a),
    .a_sign                   (a_sign),
    .mant_a_upper             (mant_a_upper),
    .mant_a_lower             (mant_a_lower),
    .exponent_b               (exponent_b),
    .b_sign                   (b_sign),
    .mant_b_upper             (mant_b_upper),
    .mant_b_lower             (mant_b_lower),
    .quotient_upper           (quotient_upper),
    .quotient_lower           (quotient_lower),
    .adder_upper              (adder_upper),
    .adder_lower              (adder_lower),
    .return_word              (return_word),
    .state_word               (state_word),
    .operand_pointer_register (operand_pointer_register),
    .word                     (dump_word)
  );

  // memory acknowledge synchroniser
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
      ack_prev <= 1'b0;
    end else begin
      ack_meta <= mem_ack;
      ack_sync <= ack_meta;
      ack_prev <= ack_sync;
    end
  end

  // state transitions
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (instruction_strobe && maintenance_mode && busy) begin // [RULE_17]
          if (instruction_word[`STEP_MODE_BIT])
            next_state = S_STEP; // [RULE_06]
          else
            next_state = S_REQ;  // [RULE_19]
        end
      end
      S_STEP: begin
        if (step_armed && (cycle_end || (step_event && step_count == 6'h01)))
          next_state = S_REQ; // [RULE_13]
      end
      S_REQ:   next_state = S_WAIT;
      S_WAIT: begin
        if (ack_rise)
          next_state = word_counter_overflow ? S_DONE : S_REQ;
      end
      S_DONE:  next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // main sequencing
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state                  <= S_IDLE;
      dump_pointer_register  <= `RST_WORD;
      step_armed             <= 1'b0;
      mem_request            <= 1'b0;
      mem_write              <= 1'b0;
      mem_address            <= `RST_WORD;
      mem_write_data         <= `RST_WORD;
      clock_run              <= 1'b0; // [RULE_22]
      clear_unit             <= 1'b0;
      return_control         <= 1'b0;
      normal_path            <= 1'b0;
      maintenance_mode       <= 1'b0; // [RULE_22]
      dump_done_flag         <= 1'b0; // [RULE_22]
      step_count             <= `RST_STEP; // [RULE_22]
      output_word_counter    <= `RST_DUMP_CNT; // [RULE_22]
      packed_state_word      <= `RST_WORD;
      subroutine_return_register <= `RST_WORD;
    end else begin
      state                      <= next_state;
      clear_unit                 <= 1'b0;
      return_control             <= 1'b0;
      normal_path                <= 1'b0;
      packed_state_word          <= state_word;
      subroutine_return_register <= return_word;
      if (diagnostic_enable_instruction)
        maintenance_mode <= 1'b1;
      case (state)
        S_IDLE: begin
          if (instruction_strobe && !(maintenance_mode && busy))
            normal_path <= 1'b1; // [RULE_17]
          if (instruction_strobe && maintenance_mode && busy) begin
            step_count             <= instruction_word[`STEP_CNT_W-1:`STEP_CNT_LSB]; // [RULE_12]
            dump_pointer_register  <= argument_address; // [RULE_03]
            output_word_counter    <= `RST_DUMP_CNT;
            dump_done_flag         <= 1'b0;
            step_armed             <= 1'b0;
            // dump-only never touches the clock or the core's state [RULE_05]
            if (instruction_word[`STEP_MODE_BIT])
              clock_run <= 1'b1; // [RULE_08]
          end
        end
        S_STEP: begin
          // the restarted clock must show up before steps are judged [RULE_08]
          if (unit_clock_active)
            step_armed <= 1'b1;
          if (step_armed && step_event && step_count != 6'h00)
            step_count <= step_count - 6'h01; // [RULE_11]
          if (step_armed && cycle_end)
            clock_run <= ~busy; // [RULE_14] [RULE_15]
          else if (step_armed && step_event && step_count == 6'h01)
            clock_run <= 1'b0;
        end
        S_REQ: begin
          mem_request    <= 1'b1; // [RULE_01]
          mem_write      <= 1'b1;
          mem_address    <= dump_pointer_register;
          mem_write_data <= dump_word;
        end
        S_WAIT: begin
          if (ack_rise) begin
            mem_request           <= 1'b0;
            mem_write             <= 1'b0;
            output_word_counter   <= counter_plus; // [RULE_01]
            dump_pointer_register <= dump_pointer_register + 18'h00001; // [RULE_03]
            if (word_counter_overflow)
              dump_done_flag <= 1'b1; // [RULE_04]
          end
        end
        S_DONE: begin
          clear_unit     <= 1'b1; // [RULE_16]
          return_control <= 1'b1; // [RULE_16]
          step_armed     <= 1'b0;
        end
        default: begin
          mem_request <= 1'b0;
          mem_write   <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- verilog/dump_word_select.v
// Purpose: selects one of the sixteen dumped words by index
// Assumes: all inputs come from logic on the same clock
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "diag_regs.vh"

module dump_word_select (
  input  wire [3:0]  word_index,
  input  wire [17:0] buffer_upper,
  input  wire [17:0] buffer_lower,
  input  wire [5:0]  shift_count,
  input  wire [11:0] instruction_low,
  input  wire [17:0] exponent_a,
  input  wire        a_sign,
  input  wire [16:0] mant_a_upper,
  input  wire [17:0] mant_a_lower,
  input  wire [17:0] exponent_b,
  input  wire        b_sign,
  input  wire [16:0] mant_b_upper,
  input  wire [17:0] mant_b_lower,
  input  wire [16:0] quotient_upper,
  input  wire [17:0] quotient_lower,
  input  wire [17:0] adder_upper,
  input  wire [17:0] adder_lower,
  input  wire [17:0] return_word,
  input  wire [17:0] state_word,
  input  wire [17:0] operand_pointer_register,
  output reg  [17:0] word
);

  // fixed dump order: buffer, shift/instr, exponent and mantissa A, exponent and mantissa B, quotient, adder, return, state, address
  always @* begin
    case (word_index) // [RULE_20]
      4'h0:    word = buffer_upper;
      4'h1:    word = buffer_lower;
      4'h2:    word = {shift_count, instruction_low};
      4'h3:    word = exponent_a;
      4'h4:    word = {mant_a_upper, a_sign};
      4'h5:    word = mant_a_lower;
      4'h6:    word = exponent_b;
      4'h7:    word = {mant_b_upper, b_sign};
      4'h8:    word = mant_b_lower;
      4'h9:    word = {quotient_upper, b_sign};
      4'ha:    word = quotient_lower;
      4'hb:    word = adder_upper;
      4'hc:    word = adder_lower;
      4'hd:    word = return_word;
      4'he:    word = state_word;
      default: word = operand_pointer_register;
    endcase
  end

endmodule

`default_nettype wire
